// ===== logic/srio_cmd_top.sv
// Purpose: cyclic command interpreter and response builder of a servo unit
// Assumes: frames arrive as bytes on aclk, servo status pins are asynchronous
// Notes: registers over AXI4-Lite, explicit messages via a one-deep mailbox

module srio_cmd_top #(
  parameter int ADDR_W = 8,
  parameter int INIT_CYCLES = srio_pkg::INIT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic cmd_valid,
  input wire logic cmd_first,
  input wire logic cmd_last,
  input wire logic [7:0] cmd_byte,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic rsp_first,
  output logic rsp_last,
  output logic [7:0] rsp_byte,
  input wire logic msg_valid,
  output logic msg_ready,
  input wire logic [31:0] msg_data,
  input wire logic alarm_in,
  input wire logic warning_in,
  input wire logic main_power_in,
  input wire logic motor_stopped_in,
  input wire logic deviation_over_in,
  output logic drive_enable,
  output logic axis_stop,
  output logic move_cancel,
  output logic fault_clear,
  output logic command_launch,
  output logic block_select,
  output logic [55:0] command_data
);
  // ----------------------------------------------------------------
  // bus front end and frame assembly
  // ----------------------------------------------------------------
  logic reg_wr, reg_wok, reg_rok;
  logic [ADDR_W-1:0] reg_waddr, reg_raddr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] reg_wstrb;
  logic fr_valid, fr_err, frame_v;
  logic [63:0] fr_data, cmd_new;

  srio_axil #(.ADDR_W(ADDR_W)) u_axil (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(s_axi_awvalid), .awready(s_axi_awready), .awaddr(s_axi_awaddr),
    .wvalid(s_axi_wvalid), .wready(s_axi_wready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb),
    .bvalid(s_axi_bvalid), .bready(s_axi_bready), .bresp(s_axi_bresp),
    .arvalid(s_axi_arvalid), .arready(s_axi_arready), .araddr(s_axi_araddr),
    .rvalid(s_axi_rvalid), .rready(s_axi_rready), .rdata(s_axi_rdata), .rresp(s_axi_rresp),
    .reg_wr(reg_wr), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .reg_wstrb(reg_wstrb),
    .reg_wok(reg_wok), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata), .reg_rok(reg_rok)
  );

  srio_frame_rx u_rx (
    .aclk(aclk), .aresetn(aresetn),
    .in_valid(cmd_valid), .in_first(cmd_first), .in_last(cmd_last), .in_byte(cmd_byte),
    .frame_valid(fr_valid), .frame(fr_data), .len_err(fr_err)
  );

  // ----------------------------------------------------------------
  // servo status pins: three stages, change taken when 2 and 3 agree
  // ----------------------------------------------------------------
  logic [4:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
  logic alarm_s, warn_s, pwr_s, stopped_s, dev_s;

  assign {dev_s, stopped_s, pwr_s, warn_s, alarm_s} = filt_r;

  always_comb begin
    filt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
      filt_r <= 5'h00;
    end else begin
      s1_r <= {deviation_over_in, motor_stopped_in, main_power_in, warning_in, alarm_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic rx_en_r, rx_en_nxt, unit_rst;
  logic [55:0] rsp_dat_r, rsp_dat_nxt;
  logic [31:0] msg_r, msg_nxt;
  logic msg_pend_r, msg_pend_nxt;
  logic [7:0] err_cnt_r, err_cnt_nxt;
  logic [63:0] cur_r, cur_nxt;
  logic drv_r, drv_nxt, stop_r, stop_nxt, ready_r, ready_nxt;
  logic cancel_r, cancel_nxt, clear_r, clear_nxt, launch_r, launch_nxt;
  logic [15:0] init_r, init_nxt;
  logic [31:0] status_w, lo_w;

  assign frame_v = fr_valid & rx_en_r;
  // reserved general bits never reach the block
  assign cmd_new = {fr_data[63:8], fr_data[7:0] & srio_pkg::CMD0_USED_MASK};
  assign unit_rst = reg_wr & (reg_waddr == ADDR_W'(srio_pkg::OFS_CONTROL)) & reg_wstrb[0]
                    & reg_wdata[srio_pkg::CTL_UNIT_RESET];
  assign msg_ready = ~msg_pend_r;
  assign lo_w = srio_pkg::merge({8'h00, rsp_dat_r[23:0]}, reg_wdata, reg_wstrb);
  assign status_w = {8'h00, err_cnt_r, 6'h00, cur_r[srio_pkg::BIT_BLOCK_SEL], dev_s, stopped_s, pwr_s,
                     warn_s, alarm_s, ready_r, ~cur_r[srio_pkg::BIT_HALT_N], stop_r, drv_r};

  always_comb begin
    reg_wok = 1'b1;
    rx_en_nxt = rx_en_r;
    rsp_dat_nxt = rsp_dat_r;
    msg_nxt = msg_r;
    msg_pend_nxt = msg_pend_r;
    err_cnt_nxt = fr_err ? err_cnt_r + 8'h01 : err_cnt_r;
    if (reg_wr) begin
      unique case (reg_waddr)
        ADDR_W'(srio_pkg::OFS_STATUS), ADDR_W'(srio_pkg::OFS_CMD_LO), ADDR_W'(srio_pkg::OFS_CMD_HI): begin
        end
        ADDR_W'(srio_pkg::OFS_CONTROL): begin
          if (reg_wstrb[0]) begin
            rx_en_nxt = reg_wdata[srio_pkg::CTL_RX_ENABLE];
          end
        end
        ADDR_W'(srio_pkg::OFS_RSP_LO): rsp_dat_nxt[23:0] = lo_w[23:0];
        ADDR_W'(srio_pkg::OFS_RSP_HI): rsp_dat_nxt[55:24] = srio_pkg::merge(rsp_dat_r[55:24], reg_wdata, reg_wstrb);
        ADDR_W'(srio_pkg::OFS_MSG): begin
          if (reg_wstrb[1] & reg_wdata[srio_pkg::MSG_PENDING]) begin
            msg_pend_nxt = 1'b0;
          end
        end
        default: reg_wok = 1'b0;
      endcase
    end
    // a new message wins over a clear in the same cycle
    if (msg_valid & msg_ready) begin
      msg_nxt = msg_data;
      msg_pend_nxt = 1'b1;
    end
  end

  always_comb begin
    reg_rok = 1'b1;
    reg_rdata = 32'h0000_0000;
    unique case (reg_raddr)
      ADDR_W'(srio_pkg::OFS_STATUS): reg_rdata = status_w;
      ADDR_W'(srio_pkg::OFS_CONTROL): reg_rdata = {30'h0, rx_en_r, 1'b0};
      ADDR_W'(srio_pkg::OFS_CMD_LO): reg_rdata = cur_r[31:0];
      ADDR_W'(srio_pkg::OFS_CMD_HI): reg_rdata = cur_r[63:32];
      ADDR_W'(srio_pkg::OFS_RSP_LO): reg_rdata = {8'h00, rsp_dat_r[23:0]};
      ADDR_W'(srio_pkg::OFS_RSP_HI): reg_rdata = rsp_dat_r[55:24];
      ADDR_W'(srio_pkg::OFS_MSG): reg_rdata = msg_pend_r ? msg_r : 32'h0000_0000;
      default: reg_rok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_en_r <= srio_pkg::CTL_RX_ENABLE_RST;
      rsp_dat_r <= 56'h0;
      msg_r <= 32'h0000_0000;
      msg_pend_r <= 1'b0;
      err_cnt_r <= 8'h00;
    end else begin
      rx_en_r <= rx_en_nxt;
      rsp_dat_r <= rsp_dat_nxt;
      msg_r <= msg_nxt;
      msg_pend_r <= msg_pend_nxt;
      err_cnt_r <= err_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // command interpretation
  // ----------------------------------------------------------------
  logic en_rise, en_fall, halt_fall, launch_rise, halt_ok, permit;

  // edges against the frame held from last time
  assign en_rise = cmd_new[srio_pkg::BIT_DRV_EN] & ~cur_r[srio_pkg::BIT_DRV_EN];
  assign en_fall = ~cmd_new[srio_pkg::BIT_DRV_EN] & cur_r[srio_pkg::BIT_DRV_EN];
  assign halt_fall = ~cmd_new[srio_pkg::BIT_HALT_N] & cur_r[srio_pkg::BIT_HALT_N];
  assign launch_rise = cmd_new[srio_pkg::BIT_LAUNCH] & ~cur_r[srio_pkg::BIT_LAUNCH];
  assign halt_ok = cmd_new[srio_pkg::BIT_HALT_N];
  assign permit = ~alarm_s & pwr_s & halt_ok & ~dev_s & ready_r & ~stop_r;

  always_comb begin
    cur_nxt = frame_v ? cmd_new : cur_r;
    drv_nxt = drv_r;
    stop_nxt = stop_r;
    cancel_nxt = 1'b0;
    clear_nxt = 1'b0;
    launch_nxt = 1'b0;
    ready_nxt = ready_r;
    init_nxt = init_r;
    if (init_r != 16'h0000) begin
      init_nxt = init_r - 16'h0001;
    end else begin
      ready_nxt = 1'b1;
    end
    if (frame_v) begin
      // fault clear acts on every frame that carries it
      clear_nxt = cmd_new[srio_pkg::BIT_FAULT_CLR];
      if (halt_fall) begin
        cancel_nxt = 1'b1;
        stop_nxt = drv_r;
      end
      if (en_fall) begin
        drv_nxt = 1'b0;
      end else if (en_rise & permit) begin
        drv_nxt = 1'b1;
      end
      launch_nxt = launch_rise & ready_r & halt_ok;
    end
    // axis first brought to rest, then the drive released
    if (stop_r & stopped_s) begin
      stop_nxt = 1'b0;
      drv_nxt = 1'b0;
    end
    if (alarm_s | ~pwr_s) begin
      drv_nxt = 1'b0;
      stop_nxt = 1'b0;
    end
    if (unit_rst) begin
      init_nxt = 16'(INIT_CYCLES);
      ready_nxt = 1'b0;
      drv_nxt = 1'b0;
      stop_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_r <= 64'h0;
      drv_r <= 1'b0;
      stop_r <= 1'b0;
      cancel_r <= 1'b0;
      clear_r <= 1'b0;
      launch_r <= 1'b0;
      ready_r <= 1'b0;
      init_r <= 16'(INIT_CYCLES);
    end else begin
      cur_r <= cur_nxt;
      drv_r <= drv_nxt;
      stop_r <= stop_nxt;
      cancel_r <= cancel_nxt;
      clear_r <= clear_nxt;
      launch_r <= launch_nxt;
      ready_r <= ready_nxt;
      init_r <= init_nxt;
    end
  end

  assign drive_enable = drv_r;
  assign axis_stop = stop_r;
  assign move_cancel = cancel_r;
  assign fault_clear = clear_r;
  assign command_launch = launch_r;
  assign block_select = cur_r[srio_pkg::BIT_BLOCK_SEL];
  assign command_data = cur_r[63:8];

  // ----------------------------------------------------------------
  // response frame per accepted command frame, frames seen mid-send folded into one
  // ----------------------------------------------------------------
  logic seen_r, seen_nxt, pend_r, pend_nxt, busy_r, busy_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [63:0] tx_r, tx_nxt;
  logic [7:0] gen_w;

  assign gen_w = {cur_r[srio_pkg::BIT_BLOCK_SEL], ready_r, pwr_s, ~cur_r[srio_pkg::BIT_HALT_N],
                  alarm_s, warn_s, drv_r, cur_r[srio_pkg::BIT_LAUNCH]};

  always_comb begin
    seen_nxt = frame_v;
    pend_nxt = pend_r;
    busy_nxt = busy_r;
    idx_nxt = idx_r;
    tx_nxt = tx_r;
    if (busy_r & rsp_ready) begin
      tx_nxt = {8'h00, tx_r[63:8]};
      idx_nxt = idx_r + 3'h1;
      busy_nxt = (idx_r != 3'(srio_pkg::FRAME_BYTES - 1));
    end
    // a frame seen mid-send queues one more answer, never more
    if (seen_r & busy_r) begin
      pend_nxt = 1'b1;
    end
    if (~busy_r & (seen_r | pend_r)) begin
      tx_nxt = {rsp_dat_r, gen_w};
      idx_nxt = 3'h0;
      busy_nxt = 1'b1;
      pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_r <= 1'b0;
      pend_r <= 1'b0;
      busy_r <= 1'b0;
      idx_r <= 3'h0;
      tx_r <= 64'h0;
    end else begin
      seen_r <= seen_nxt;
      pend_r <= pend_nxt;
      busy_r <= busy_nxt;
      idx_r <= idx_nxt;
      tx_r <= tx_nxt;
    end
  end

  assign rsp_valid = busy_r;
  assign rsp_byte = tx_r[7:0];
  assign rsp_first = busy_r & (idx_r == 3'h0);
  assign rsp_last = busy_r & (idx_r == 3'(srio_pkg::FRAME_BYTES - 1));
endmodule

// ===== logic/srio_pkg.sv
// Purpose: shared constants of the servo remote I/O command block
// Assumes: 200 MHz aclk, byte 0 of a frame sits in bits [7:0]
// Notes: register offsets are byte addresses on the AXI4-Lite bus
package srio_pkg;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BYTES = 8;
  localparam int BIT_BLOCK_SEL = 7;
  localparam int BIT_FAULT_CLR = 5;
  localparam int BIT_HALT_N = 4;
  localparam int BIT_DRV_EN = 1;
  localparam int BIT_LAUNCH = 0;
  localparam logic [7:0] CMD0_USED_MASK = 8'hb3;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_CMD_LO = 8'h08;
  localparam logic [7:0] OFS_CMD_HI = 8'h0c;
  localparam logic [7:0] OFS_RSP_LO = 8'h10;
  localparam logic [7:0] OFS_RSP_HI = 8'h14;
  localparam logic [7:0] OFS_MSG = 8'h18;
  localparam int CTL_UNIT_RESET = 0;
  localparam int CTL_RX_ENABLE = 1;
  localparam logic CTL_RX_ENABLE_RST = 1'b1;
  localparam int MSG_PENDING = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// ===== logic/srio_axil.sv
// Purpose: AXI4-Lite slave front end for the command block registers
// Assumes: one write and one read outstanding at most
// Notes: bvalid one cycle after both halves held, rvalid one after ar
module srio_axil #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic reg_wr,
  output logic [ADDR_W-1:0] reg_waddr,
  output logic [31:0] reg_wdata,
  output logic [3:0] reg_wstrb,
  input wire logic reg_wok,
  output logic [ADDR_W-1:0] reg_raddr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rok
);
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;

  assign awready = ~aw_full_r & ~bvalid_r;
  assign wready = ~w_full_r & ~bvalid_r;
  assign arready = ~rvalid_r;
  assign reg_wr = aw_full_r & w_full_r & ~bvalid_r;
  assign reg_waddr = awaddr_r;
  assign reg_wdata = wdata_r;
  assign reg_wstrb = wstrb_r;
  assign reg_raddr = araddr;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  always_comb begin
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (awvalid & awready) begin
      aw_full_nxt = 1'b1;
      awaddr_nxt = awaddr;
    end
    if (wvalid & wready) begin
      w_full_nxt = 1'b1;
      wdata_nxt = wdata;
      wstrb_nxt = wstrb;
    end
    if (reg_wr) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = reg_wok ? srio_pkg::RESP_OKAY : srio_pkg::RESP_SLVERR;
    end else if (bvalid_r & bready) begin
      bvalid_nxt = 1'b0;
    end
    if (arvalid & arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = reg_rok ? reg_rdata : 32'h0000_0000;
      rresp_nxt = reg_rok ? srio_pkg::RESP_OKAY : srio_pkg::RESP_SLVERR;
    end else if (rvalid_r & rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end
endmodule

// ===== logic/srio_frame_rx.sv
// Purpose: gathers command bytes into whole eight-byte frames
// Assumes: byte source runs on aclk, marks first and last byte
// Notes: any frame not exactly eight bytes long is dropped
module srio_frame_rx (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  input wire logic in_first,
  input wire logic in_last,
  input wire logic [7:0] in_byte,
  output logic frame_valid,
  output logic [63:0] frame,
  output logic len_err
);
  logic open_r, open_nxt, bad_r, bad_nxt, fv_r, fv_nxt, err_r, err_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [63:0] buf_r, buf_nxt;
  logic [3:0] idx;

  assign frame_valid = fv_r;
  assign frame = buf_r;
  assign len_err = err_r;

  always_comb begin
    open_nxt = open_r;
    bad_nxt = bad_r;
    cnt_nxt = cnt_r;
    buf_nxt = buf_r;
    fv_nxt = 1'b0;
    err_nxt = 1'b0;
    idx = in_first ? 4'h0 : cnt_r;
    if (in_valid & (in_first | open_r)) begin
      if (in_first) begin
        bad_nxt = 1'b0;
      end
      // stray bytes past the eighth spoil the frame
      if (idx < 4'(srio_pkg::FRAME_BYTES)) begin
        buf_nxt[idx[2:0]*8 +: 8] = in_byte;
        cnt_nxt = idx + 4'h1;
      end else begin
        bad_nxt = 1'b1;
      end
      open_nxt = ~in_last;
      if (in_last) begin
        if (~bad_nxt & (idx == 4'(srio_pkg::FRAME_BYTES - 1))) begin
          fv_nxt = 1'b1;
        end else begin
          err_nxt = 1'b1;
        end
        cnt_nxt = 4'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_r <= 1'b0;
      bad_r <= 1'b0;
      cnt_r <= 4'h0;
      buf_r <= 64'h0;
      fv_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      open_r <= open_nxt;
      bad_r <= bad_nxt;
      cnt_r <= cnt_nxt;
      buf_r <= buf_nxt;
      fv_r <= fv_nxt;
      err_r <= err_nxt;
    end
  end
endmodule

// ===== test/srio_assertions.sv
// Purpose: port checks of the command interpreter
// Assumes: one aclk domain, synchronous active-low reset
// Notes: status inputs need up to 4 cycles through the synchroniser
module srio_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic alarm_in,
  input wire logic main_power_in,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic rsp_first,
  input wire logic rsp_last,
  input wire logic [7:0] rsp_byte,
  input wire logic drive_enable,
  input wire logic axis_stop,
  input wire logic move_cancel,
  input wire logic fault_clear,
  input wire logic command_launch,
  input wire logic block_select
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_held;
    rsp_valid && !rsp_ready;
  endsequence
  a_launch_pulse: assert property (command_launch |=> !command_launch) else $error("long launch");
  a_cancel_pulse: assert property (move_cancel |=> !move_cancel) else $error("long cancel");
  a_clear_pulse: assert property (fault_clear |=> !fault_clear) else $error("long clear");
  a_rsp_hold: assert property (s_held |=> rsp_valid && $stable(rsp_byte)) else $error("byte moved");
  a_first_last: assert property (rsp_valid && rsp_first |-> !rsp_last) else $error("short frame");
  a_echo_select: assert property (rsp_valid && rsp_first |-> rsp_byte[7] == block_select) else $error("echo");
  a_alarm_off: assert property (alarm_in [*6] |-> !drive_enable) else $error("drive in alarm");
  a_power_off: assert property (!main_power_in [*6] |-> !drive_enable) else $error("drive unpowered");
  a_stop_off: assert property ($fell(axis_stop) |-> !drive_enable) else $error("drive after stop");
endmodule

bind srio_cmd_top srio_assertions u_chk (.*);

// ===== test/srio_master_model.sv
// Purpose: fieldbus master seen from the unit's byte links
// Assumes: bench pulses go for one cycle with frame set
// Notes: stall halves the response take rate
module srio_master_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic stall,
  input wire logic [63:0] frame,
  output logic cmd_valid,
  output logic cmd_first,
  output logic cmd_last,
  output logic [7:0] cmd_byte,
  input wire logic rsp_valid,
  input wire logic rsp_first,
  input wire logic rsp_last,
  input wire logic [7:0] rsp_byte,
  output logic rsp_ready,
  output logic [63:0] rsp_frame,
  output int rsp_count
);
  logic [63:0] acc;
  int idx;
  initial begin
    {cmd_valid, cmd_first, cmd_last} = 3'h0;
    cmd_byte = 8'h00;
    forever begin
      @(posedge aclk);
      if (go) begin
        for (int k = 0; k < 8; k++) begin
          cmd_valid <= 1'b1; // whole frame, bytes taken from frame in order
          cmd_first <= k == 0;
          cmd_last <= k == 7;
          cmd_byte <= frame[8*k +: 8];
          @(posedge aclk);
        end
        cmd_valid <= 1'b0;
        cmd_last <= 1'b0;
        cmd_byte <= ~frame[63:56]; // no stale byte on an idle line
      end
    end
  end
  always @(posedge aclk) begin
    rsp_ready <= stall ? !rsp_ready : 1'b1;
    if (rsp_valid && rsp_ready) begin
      idx = rsp_first ? 0 : idx + 1;
      acc[8*idx +: 8] = rsp_byte;
      if (rsp_last) begin
        rsp_frame <= acc;
        rsp_count <= rsp_count + 1;
      end
    end
  end
endmodule

// ===== test/testbench.sv
// Purpose: self-checking bench of the command interpreter
// Assumes: short init count, master model on the byte links
// Notes: status inputs pass a synchroniser, hence settle waits
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [55:0] D = 56'h77665544332211;
  logic aclk = 0, aresetn = 0, go = 0, stall = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q, msg_data = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, msg_ready;
  logic cmd_valid, cmd_first, cmd_last, rsp_valid, rsp_ready, rsp_first, rsp_last;
  logic [7:0] cmd_byte, rsp_byte;
  logic msg_valid = 0, warning_in = 0, deviation_over_in = 0;
  logic alarm_in = 0, main_power_in = 1, motor_stopped_in = 0;
  logic drive_enable, axis_stop, move_cancel, fault_clear, command_launch, block_select;
  logic [55:0] command_data;
  logic [63:0] frame = 64'h0, rsp_frame;
  int rsp_count, n_clr = 0, n_can = 0, n_go = 0, num_errors = 0, samples_checked = 0;
  srio_cmd_top #(.INIT_CYCLES(8)) u_dut (.*);
  srio_master_model u_far (.*);
  initial forever #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    n_clr += fault_clear;
    n_can += move_cancel;
    n_go += command_launch;
  end
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic fail;
    num_errors++;
    $display("BAD %0t wait ran out", $time);
    conclude();
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tr, tb;
    if (wr) begin
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    end else begin
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
    end
    repeat (40) begin
      #1;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      tb = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (tb) begin
        {s_axi_bready, s_axi_rready} <= 2'h0;
        @(posedge aclk);
        return;
      end
    end
    fail();
  endtask
  task automatic send(input logic [7:0] b0);
    int c;
    c = rsp_count;
    frame <= {D, b0};
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (80) begin
      @(posedge aclk);
      if (rsp_count != c) return;
    end
    fail();
  endtask
  task automatic t_regs;
    axi(1, srio_pkg::OFS_CONTROL, 32'h3, 4'h1);
    axi(0, srio_pkg::OFS_STATUS, 0, 0);
    chk(q[3], 1'b0);
    repeat (12) @(posedge aclk);
    axi(0, srio_pkg::OFS_STATUS, 0, 0);
    chk(q[3], 1'b1);
    axi(1, srio_pkg::OFS_RSP_LO, 32'h55a1b2c3, 4'h7);
    axi(0, 8'h1c, 0, 0);
    chk(r, srio_pkg::RESP_SLVERR);
    $display("regs done");
  endtask
  task automatic t_msg;
    msg_data <= 32'hc0de1234;
    msg_valid <= 1'b1;
    @(posedge aclk);
    msg_valid <= 1'b0;
    axi(0, srio_pkg::OFS_MSG, 0, 0);
    chk({msg_ready, q}, {1'b0, 32'hc0de1234});
    axi(1, srio_pkg::OFS_MSG, 32'h100, 4'h2);
    chk(msg_ready, 1'b1);
    $display("msg done");
  endtask
  task automatic t_enable;
    send(8'h10); // halt bit high for normal running
    send(8'hde);
    chk({drive_enable, block_select, command_data}, {2'h3, D});
    chk(rsp_frame[31:0], 32'ha1b2c3e2);
    axi(0, srio_pkg::OFS_CMD_LO, 0, 0);
    chk(q, 32'h33221192);
    send(8'h10);
    chk(drive_enable, 1'b0);
    $display("enable done");
  endtask
  task automatic t_estop;
    int c0;
    send(8'h12);
    c0 = n_can;
    send(8'h02);
    chk({drive_enable, axis_stop, rsp_frame[4], n_can - c0}, {3'h7, 32'h1});
    send(8'h00);
    send(8'h02);
    chk(drive_enable, 1'b0);
    motor_stopped_in <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({drive_enable, axis_stop}, 2'h0);
    send(8'h12);
    chk(drive_enable, 1'b0);
    send(8'h10);
    send(8'h12);
    chk(drive_enable, 1'b1);
    $display("estop done");
  endtask
  task automatic t_alarm;
    int c0;
    stall <= 1'b1;
    alarm_in <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(drive_enable, 1'b0);
    send(8'h10);
    send(8'h12);
    chk({drive_enable, rsp_frame[3]}, 2'h1);
    alarm_in <= 1'b0; // cause gone before the clear request
    repeat (6) @(posedge aclk);
    c0 = n_clr;
    send(8'h32);
    chk({drive_enable, n_clr - c0}, 33'h1);
    send(8'h10);
    c0 = n_go;
    send(8'h13);
    chk({drive_enable, n_go - c0}, 33'h100000001);
    deviation_over_in <= 1'b1;
    repeat (6) @(posedge aclk);
    send(8'h11);
    send(8'h13);
    chk(drive_enable, 1'b0);
    deviation_over_in <= 1'b0;
    repeat (6) @(posedge aclk);
    send(8'h11);
    send(8'h13);
    chk(drive_enable, 1'b1);
    main_power_in <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(drive_enable, 1'b0);
    $display("alarm done");
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
    t_regs();
    t_msg();
    t_enable();
    t_estop();
    t_alarm();
    conclude();
  end
endmodule
